// ===== rtl/sfcf_cache_mem.sv
// Byte store of the fetch cache with registered read data
`timescale 1ns/100ps
module sfcf_cache_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem_q[waddr] <= wdata;
    end
  end

  // A write also passes straight to the read register, so a fresh byte is
  // presented on the same edge as a cached one would be
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= we ? wdata : mem_q[raddr];
    end
  end
endmodule

// ===== rtl/sfcf_pkg.sv
// Shared constants and types for the serial flash code fetch controller
package sfcf_pkg;
  localparam int CLK_MHZ  = 250;
  localparam int SLOW_MHZ = 30;
  localparam int FAST_MHZ = 60;
  // Half periods of the serial clock, rounded up so the rate never exceeds the setting
  localparam int SLOW_HALF = (CLK_MHZ + 2 * SLOW_MHZ - 1) / (2 * SLOW_MHZ);
  localparam int FAST_HALF = (CLK_MHZ + 2 * FAST_MHZ - 1) / (2 * FAST_MHZ);
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_DUAL_READ = 8'h3b;
  localparam logic [7:0] DUMMY_BYTE   = 8'h00;
  localparam logic [7:0] PAD_BYTE     = 8'h00;

  localparam logic [23:0] SIG_ADDR  = 24'h00fffa;
  localparam logic [23:0] EXEC_ADDR = 24'h000000;
  localparam logic [31:0] SIG_WORD  = 32'h32444655;

  localparam int HDR_BYTES = 5;
  localparam int CMD_BYTES = 8;

  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_LEN   = 8'h04;
  localparam logic [7:0] REG_CMD0  = 8'h08;
  localparam logic [7:0] REG_CMD1  = 8'h0c;
  localparam logic [7:0] REG_RESP0 = 8'h10;
  localparam logic [7:0] REG_RESP1 = 8'h14;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DUAL_BIT  = 1;
  localparam int STAT_EXT_BIT   = 4;
  localparam int STAT_BOOT_BIT  = 5;
  localparam int STAT_FAST_BIT  = 6;

  localparam logic [7:0] LEN_RST  = 8'h00;
  localparam logic [7:0] CMD_RST  = 8'h00;
  localparam logic       DUAL_RST = 1'b0;

  typedef enum logic [1:0] {E_IDLE, E_SHIFT, E_HOLD, E_END} sfcf_eng_t;
  typedef enum logic [1:0] {B_STRAP, B_REQ, B_WAIT, B_DONE} sfcf_boot_t;
endpackage

// ===== rtl/sfcf_top.sv
// Serial flash controller: code fetch with cache, command buffer path, boot check
//
// Overview of operation
// - At power-up read signature at 0xFFFA; if valid, enable external code from 0.
// - Without a valid signature, external code stays disabled; internal ROM runs.
// - Single-mode code read: select low, opcode 0x0B, 24-bit address, one dummy byte.
// - Single mode shifts one data byte in eight clocks, then signals ready.
// - Sequential next address clocks one more byte; otherwise select is released.
// - Dual read is used only at the slower clock setting.
// - Dual-mode code read: select low, opcode 0x3B, 24-bit address, one dummy byte.
// - Dual mode moves a data byte in four clocks over both data lines.
// - Speed strap on the data output is latched after reset; high means fast.
// - 32-byte fetch cache with base and length; a jump reloads the base.
// - Each fetched byte enters the cache; past 32 bytes the base advances.
// - A jump inside the cached range answers in one clock without flash access.
// - Eight-byte command buffer, eight-byte response buffer, byte length register.
// - Start bit drops select and gives eight clocks per programmed byte.
// - After the opcode byte, input data are captured into the response buffer.
// - Bytes beyond the command buffer are sent as don't-care values.
// - Command path serves firmware running from internal RAM or ROM.
// - Select goes high once the command transfer has completed.
// - Identity read with length four leaves three reply bytes in the response buffer.
`timescale 1ns/100ps
module sfcf_top #(
  parameter int ADDR_W      = 24,
  parameter int LEN_W       = 8,
  parameter int CACHE_DEPTH = 32
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              fetch_req,
  input  wire logic [ADDR_W-1:0] fetch_addr,
  output logic                   fetch_ready,
  output logic      [7:0]        fetch_data,
  output logic                   ext_code_en,
  output logic                   boot_done,
  output logic                   flash_sel_n,
  output logic                   flash_sck,
  output logic                   sdo_out,
  output logic                   sdo_oe_n,
  input  wire logic              sdo_in,
  input  wire logic              serial_in_line
);
  localparam int AW   = $clog2(CACHE_DEPTH);
  localparam int CL_W = AW + 1;
  localparam logic [CL_W-1:0]  CACHE_FULL = CL_W'(CACHE_DEPTH);
  localparam logic [LEN_W-1:0] HDR_IDX    = LEN_W'(sfcf_pkg::HDR_BYTES);
  localparam logic [LEN_W-1:0] CMD_IDX    = LEN_W'(sfcf_pkg::CMD_BYTES);
  localparam logic [2:0]       SLOW_H     = 3'(sfcf_pkg::SLOW_HALF);
  localparam logic [2:0]       FAST_H     = 3'(sfcf_pkg::FAST_HALF);

  sfcf_pkg::sfcf_eng_t  state_q;
  sfcf_pkg::sfcf_boot_t bstate_q;
  logic                 sdo_m_q, sdo_s_q, sin_m_q, sin_s_q;
  logic [1:0]           strap_cnt_q;
  logic                 strap_done_q, speed_fast_q;
  logic                 dual_en_q, cmd_busy_q;
  logic [LEN_W-1:0]     len_q;
  logic [7:0]           cmd_q [sfcf_pkg::CMD_BYTES];
  logic [7:0]           resp_q [sfcf_pkg::CMD_BYTES];
  logic                 job_cmd_q, sck_q, dual_q;
  logic [LEN_W-1:0]     idx_q;
  logic [2:0]           div_q;
  logic [3:0]           bits_q;
  logic [7:0]           tx_q, rx_q;
  logic [ADDR_W-1:0]    rd_addr_q, pend_addr_q, base_q;
  logic                 pend_q, rdy_q;
  logic [CL_W-1:0]      clen_q;
  logic [1:0]           boot_k_q;
  logic                 match_q;

  logic                 wr_en, rd_setup, start_wr, dual_eff;
  logic [2:0]           half;
  logic                 tick, fall, byte_done, data_done, jump, cmd_fin;
  logic [7:0]           rx_next, sig_b;
  logic [LEN_W-1:0]     nidx;
  logic                 req_v, hit;
  logic [ADDR_W-1:0]    req_a, diff;
  logic [31:0]          ctrl_rd;

  // Input pins pass two flops before use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sdo_m_q <= 1'b0;
      sdo_s_q <= 1'b0;
      sin_m_q <= 1'b0;
      sin_s_q <= 1'b0;
    end
    else
    begin
      sdo_m_q <= sdo_in;
      sdo_s_q <= sdo_m_q;
      sin_m_q <= serial_in_line;
      sin_s_q <= sin_m_q;
    end
  end

  // Strap is caught after release, once the synchroniser has settled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      speed_fast_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      if (strap_cnt_q == sfcf_pkg::STRAP_WAIT)
      begin
        speed_fast_q <= sdo_s_q;
        strap_done_q <= 1'b1;
      end
      else
      begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  assign half     = speed_fast_q ? FAST_H : SLOW_H;
  assign dual_eff = dual_en_q & ~speed_fast_q;
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign start_wr = wr_en && paddr == sfcf_pkg::REG_CTRL && pwdata[sfcf_pkg::CTRL_START_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dual_en_q <= sfcf_pkg::DUAL_RST;
      len_q     <= sfcf_pkg::LEN_RST;
    end
    else if (wr_en)
    begin
      if (paddr == sfcf_pkg::REG_CTRL)
      begin
        dual_en_q <= pwdata[sfcf_pkg::CTRL_DUAL_BIT];
      end
      if (paddr == sfcf_pkg::REG_LEN && !cmd_busy_q)
      begin
        len_q <= pwdata[LEN_W-1:0];
      end
    end
  end

  // Start is refused while busy or with a zero length
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_busy_q <= 1'b0;
    end
    else if (start_wr && !cmd_busy_q && len_q != '0)
    begin
      cmd_busy_q <= 1'b1;
    end
    else if (cmd_fin)
    begin
      cmd_busy_q <= 1'b0;
    end
  end

  genvar gi;
  for (gi = 0; gi < sfcf_pkg::CMD_BYTES; gi++)
  begin : g_cmd
    localparam logic [7:0] OFS = (gi < 4) ? sfcf_pkg::REG_CMD0 : sfcf_pkg::REG_CMD1;
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        cmd_q[gi] <= sfcf_pkg::CMD_RST;
      end
      else if (wr_en && paddr == OFS && pstrb[gi % 4] && !cmd_busy_q)
      begin
        cmd_q[gi] <= pwdata[8 * (gi % 4) +: 8];
      end
    end
  end

  // Serial engine timing
  assign tick      = (state_q == sfcf_pkg::E_SHIFT || state_q == sfcf_pkg::E_END)
                     && div_q == half - 3'h1;
  assign fall      = tick && state_q == sfcf_pkg::E_SHIFT && sck_q;
  assign byte_done = fall && bits_q == 4'h1;
  assign data_done = byte_done && !job_cmd_q && idx_q == HDR_IDX;
  assign cmd_fin   = tick && state_q == sfcf_pkg::E_END && job_cmd_q;
  assign nidx      = idx_q + LEN_W'(1);
  // Dual: first bit of each pair arrives on the input line, second on the output line
  assign rx_next   = dual_q ? {rx_q[5:0], sin_s_q, sdo_s_q} : {rx_q[6:0], sin_s_q};

  function automatic logic [7:0] hdr_byte(input logic [LEN_W-1:0] i,
                                          input logic [ADDR_W-1:0] a,
                                          input logic d);
    case (i)
      LEN_W'(0): hdr_byte = d ? sfcf_pkg::OP_DUAL_READ : sfcf_pkg::OP_FAST_READ;
      LEN_W'(1): hdr_byte = a[23:16];
      LEN_W'(2): hdr_byte = a[15:8];
      LEN_W'(3): hdr_byte = a[7:0];
      default:   hdr_byte = sfcf_pkg::DUMMY_BYTE;
    endcase
  endfunction

  // Request source: boot check first, then the processor once external code is on
  assign req_v = (bstate_q == sfcf_pkg::B_REQ) || (fetch_req && ext_code_en);
  assign req_a = (bstate_q == sfcf_pkg::B_REQ) ?
                 sfcf_pkg::SIG_ADDR + ADDR_W'(boot_k_q) : fetch_addr;
  assign diff  = req_a - base_q;
  assign hit   = req_v && diff < ADDR_W'(clen_q);
  assign jump  = state_q == sfcf_pkg::E_IDLE && pend_q && strap_done_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q     <= sfcf_pkg::E_IDLE;
      job_cmd_q   <= 1'b0;
      idx_q       <= '0;
      div_q       <= 3'h0;
      sck_q       <= 1'b0;
      bits_q      <= 4'h0;
      tx_q        <= 8'h00;
      rx_q        <= 8'h00;
      dual_q      <= 1'b0;
      rd_addr_q   <= '0;
      flash_sel_n <= 1'b1;
      flash_sck   <= 1'b0;
      sdo_out     <= 1'b0;
      sdo_oe_n    <= 1'b1;
    end
    else
    begin
      div_q <= (tick || state_q == sfcf_pkg::E_IDLE || state_q == sfcf_pkg::E_HOLD)
               ? 3'h0 : div_q + 3'h1;
      case (state_q)
        sfcf_pkg::E_IDLE:
        begin
          flash_sel_n <= 1'b1;
          sdo_oe_n    <= 1'b1;
          if (jump)
          begin
            job_cmd_q   <= 1'b0;
            idx_q       <= '0;
            rd_addr_q   <= pend_addr_q;
            tx_q        <= hdr_byte('0, pend_addr_q, dual_eff);
            sdo_out     <= 1'(hdr_byte('0, pend_addr_q, dual_eff) >> 7);
            bits_q      <= 4'h8;
            dual_q      <= 1'b0;
            flash_sel_n <= 1'b0;
            sdo_oe_n    <= 1'b0;
            state_q     <= sfcf_pkg::E_SHIFT;
          end
          else if (cmd_busy_q && strap_done_q)
          begin
            job_cmd_q   <= 1'b1;
            idx_q       <= '0;
            tx_q        <= cmd_q[0];
            sdo_out     <= cmd_q[0][7];
            bits_q      <= 4'h8;
            dual_q      <= 1'b0;
            flash_sel_n <= 1'b0;
            sdo_oe_n    <= 1'b0;
            state_q     <= sfcf_pkg::E_SHIFT;
          end
        end
        sfcf_pkg::E_SHIFT:
        begin
          if (tick && !sck_q)
          begin
            sck_q     <= 1'b1;
            flash_sck <= 1'b1;
          end
          else if (fall)
          begin
            // Input is taken late in the high phase, output moves on the fall
            sck_q     <= 1'b0;
            flash_sck <= 1'b0;
            rx_q      <= rx_next;
            tx_q      <= {tx_q[6:0], 1'b0};
            sdo_out   <= tx_q[6];
            bits_q    <= bits_q - 4'h1;
            if (byte_done)
            begin
              if (job_cmd_q)
              begin
                if (nidx == len_q)
                begin
                  state_q <= sfcf_pkg::E_END;
                end
                else
                begin
                  idx_q   <= nidx;
                  tx_q    <= (nidx < CMD_IDX) ? cmd_q[nidx[2:0]] : sfcf_pkg::PAD_BYTE;
                  sdo_out <= (nidx < CMD_IDX) ? cmd_q[nidx[2:0]][7] : 1'b0;
                  bits_q  <= 4'h8;
                end
              end
              else if (data_done)
              begin
                state_q <= sfcf_pkg::E_HOLD;
              end
              else
              begin
                idx_q    <= nidx;
                tx_q     <= hdr_byte(nidx, rd_addr_q, dual_eff);
                sdo_out  <= 1'(hdr_byte(nidx, rd_addr_q, dual_eff) >> 7);
                dual_q   <= (nidx == HDR_IDX) && dual_eff;
                bits_q   <= ((nidx == HDR_IDX) && dual_eff) ? 4'h4 : 4'h8;
                sdo_oe_n <= (nidx == HDR_IDX) && dual_eff;
              end
            end
          end
        end
        sfcf_pkg::E_HOLD:
        begin
          // Select stays low between bytes of a sequential run
          if (cmd_busy_q || hit || (boot_done && !ext_code_en))
          begin
            state_q <= sfcf_pkg::E_END;
          end
          else if (pend_q)
          begin
            if (pend_addr_q == rd_addr_q + ADDR_W'(1))
            begin
              rd_addr_q <= pend_addr_q;
              tx_q      <= sfcf_pkg::DUMMY_BYTE;
              bits_q    <= dual_q ? 4'h4 : 4'h8;
              state_q   <= sfcf_pkg::E_SHIFT;
            end
            else
            begin
              state_q <= sfcf_pkg::E_END;
            end
          end
        end
        sfcf_pkg::E_END:
        begin
          flash_sel_n <= 1'b1;
          sdo_oe_n    <= 1'b1;
          if (tick)
          begin
            state_q <= sfcf_pkg::E_IDLE;
          end
        end
        default:
        begin
          state_q <= sfcf_pkg::E_IDLE;
        end
      endcase
    end
  end

  // One outstanding miss; the answer itself clears it, a new miss sets it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_q      <= 1'b0;
      pend_addr_q <= '0;
    end
    else if (req_v && !hit)
    begin
      pend_q      <= 1'b1;
      pend_addr_q <= req_a;
    end
    else if (data_done)
    begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      base_q <= '0;
      clen_q <= '0;
    end
    else if (jump)
    begin
      base_q <= pend_addr_q;
      clen_q <= '0;
    end
    else if (data_done)
    begin
      if (clen_q == CACHE_FULL)
      begin
        base_q <= base_q + ADDR_W'(1);
      end
      else
      begin
        clen_q <= clen_q + CL_W'(1);
      end
    end
  end

  sfcf_cache_mem #(
    .WIDTH (8),
    .DEPTH (CACHE_DEPTH)
  ) u_cache (
    .clk   (pclk),
    .rst_n (presetn),
    .we    (data_done),
    .waddr (rd_addr_q[AW-1:0]),
    .wdata (rx_next),
    .raddr (req_a[AW-1:0]),
    .rdata (fetch_data)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdy_q       <= 1'b0;
      fetch_ready <= 1'b0;
    end
    else
    begin
      rdy_q       <= data_done | hit;
      fetch_ready <= (data_done | hit) & boot_done;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < sfcf_pkg::CMD_BYTES; i++)
      begin
        resp_q[i] <= 8'h00;
      end
    end
    else if (byte_done && job_cmd_q && idx_q != '0 && idx_q <= CMD_IDX)
    begin
      resp_q[3'(idx_q - LEN_W'(1))] <= rx_next;
    end
  end

  // Signature bytes compared one by one, first byte at the lowest address
  assign sig_b = sfcf_pkg::SIG_WORD[{~boot_k_q, 3'h0} +: 8];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bstate_q    <= sfcf_pkg::B_STRAP;
      boot_k_q    <= 2'h0;
      match_q     <= 1'b1;
      ext_code_en <= 1'b0;
      boot_done   <= 1'b0;
    end
    else
    begin
      case (bstate_q)
        sfcf_pkg::B_STRAP:
        begin
          if (strap_done_q)
          begin
            bstate_q <= sfcf_pkg::B_REQ;
          end
        end
        sfcf_pkg::B_REQ:
        begin
          bstate_q <= sfcf_pkg::B_WAIT;
        end
        sfcf_pkg::B_WAIT:
        begin
          if (rdy_q)
          begin
            match_q <= match_q && fetch_data == sig_b;
            if (boot_k_q == 2'h3)
            begin
              // Processor starts at EXEC_ADDR when enabled, else stays internal
              ext_code_en <= match_q && fetch_data == sig_b;
              boot_done   <= 1'b1;
              bstate_q    <= sfcf_pkg::B_DONE;
            end
            else
            begin
              boot_k_q <= boot_k_q + 2'h1;
              bstate_q <= sfcf_pkg::B_REQ;
            end
          end
        end
        sfcf_pkg::B_DONE:
        begin
          bstate_q <= sfcf_pkg::B_DONE;
        end
        default:
        begin
          bstate_q <= sfcf_pkg::B_STRAP;
        end
      endcase
    end
  end

  always_comb
  begin
    ctrl_rd                          = 32'h0000_0000;
    ctrl_rd[sfcf_pkg::CTRL_START_BIT] = cmd_busy_q;
    ctrl_rd[sfcf_pkg::CTRL_DUAL_BIT]  = dual_en_q;
    ctrl_rd[sfcf_pkg::STAT_EXT_BIT]   = ext_code_en;
    ctrl_rd[sfcf_pkg::STAT_BOOT_BIT]  = boot_done;
    ctrl_rd[sfcf_pkg::STAT_FAST_BIT]  = speed_fast_q;
  end

  // Zero-wait slave: data and error are prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= 1'b1;
      if (rd_setup)
      begin
        pslverr <= 1'b0;
        case (paddr)
          sfcf_pkg::REG_CTRL:  prdata <= ctrl_rd;
          sfcf_pkg::REG_LEN:   prdata <= 32'(len_q);
          sfcf_pkg::REG_CMD0:  prdata <= {cmd_q[3], cmd_q[2], cmd_q[1], cmd_q[0]};
          sfcf_pkg::REG_CMD1:  prdata <= {cmd_q[7], cmd_q[6], cmd_q[5], cmd_q[4]};
          sfcf_pkg::REG_RESP0: prdata <= {resp_q[3], resp_q[2], resp_q[1], resp_q[0]};
          sfcf_pkg::REG_RESP1: prdata <= {resp_q[7], resp_q[6], resp_q[5], resp_q[4]};
          default:
          begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// ===== verification/sfcf_asserts.sv
// Checker of bus, fetch and flash pin timing of the controller
`timescale 1ns/100ps
module sfcf_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pslverr,
  input wire logic       fetch_ready,
  input wire logic       ext_code_en,
  input wire logic       boot_done,
  input wire logic       flash_sel_n,
  input wire logic       flash_sck,
  input wire logic       sdo_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_IDLE_LOW: assert property (flash_sel_n |-> !flash_sck)
    else $error("sck high while idle");
  AST_OE_IDLE: assert property (flash_sel_n |-> sdo_oe_n)
    else $error("data pin driven while idle");
  AST_UNMAPPED: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("unmapped access without error");
  AST_NO_EXT_FETCH: assert property (!ext_code_en |-> !fetch_ready)
    else $error("fetch answered without external code");
  AST_EXT_AFTER_BOOT: assert property (!boot_done |-> !ext_code_en)
    else $error("external code before check done");
  AST_READY_PULSE: assert property (fetch_ready |=> !fetch_ready)
    else $error("ready longer than one cycle");
  AST_HALF_PERIOD: assert property ($changed(flash_sck) |=> $stable(flash_sck) [*2])
    else $error("serial clock too fast");
  AST_FRAME_START: assert property ($fell(flash_sel_n) |-> (!flash_sck && !sdo_oe_n) [*2])
    else $error("bad frame start");
  AST_BOOT_HOLD: assert property (boot_done |=> boot_done)
    else $error("check done dropped");
  COV_FETCH: cover property (fetch_ready);
  COV_FRAME: cover property ($fell(flash_sel_n));
  COV_BOOT: cover property ($rose(boot_done));
endmodule

// ===== verification/sfcf_flash_model.sv
// Behavioural serial flash in mode 0 on the far side of the controller
`timescale 1ns/100ps
module sfcf_flash_model #(
  parameter logic [23:0] ID = 24'h112233 // Arbitrary identity bytes
) (
  input  wire logic sel_n,
  input  wire logic sck,
  input  wire logic pin,
  input  wire logic good,
  output logic      miso,
  output logic      dq0,
  output logic      dq0_en
);
  logic [63:0] sr = 64'h0;
  logic [7:0]  op = 8'h00;
  logic [7:0]  v;
  logic [23:0] adr = 24'h0;
  int          cnt = 0;
  int          nf = 0;
  int          k;
  initial {miso, dq0, dq0_en} = 3'h0;
  function automatic logic [7:0] fm(input logic [23:0] a);
    if (good && a >= 24'h00fffa && a < 24'h00fffe)
      return sfcf_pkg::SIG_WORD[31 - 8 * (a - 24'h00fffa) -: 8];
    return a[7:0] ^ 8'h5a;
  endfunction
  always @(negedge sel_n)
  begin
    cnt = 0;
    sr = 64'h0;
    op = 8'h00;
    nf++;
  end
  // Released line flips so no stale bit looks valid
  always @(posedge sel_n)
  begin
    miso = ~miso;
    dq0_en = 0;
  end
  always @(posedge sck)
    if (!sel_n)
    begin
      sr = {sr[62:0], pin};
      cnt++;
      if (cnt == 8) op = sr[7:0];
      if (cnt == 32) adr = sr[23:0];
    end
  always @(negedge sck)
    if (!sel_n)
    begin
      k = cnt - 40;
      if (op == 8'h9f && cnt >= 8 && cnt < 32) miso = ID[31 - cnt];
      if (op == 8'h0b && k >= 0)
      begin
        v = fm(adr + 24'(k / 8));
        miso = v[7 - k % 8];
      end
      if (op == 8'h3b && k >= 0)
      begin
        v = fm(adr + 24'(k / 4));
        miso = v[7 - 2 * (k % 4)];
        dq0 = v[6 - 2 * (k % 4)];
        dq0_en = 1;
      end
    end
endmodule

// ===== verification/sfcf_tb.sv
// Self-checking bench of the flash code fetch controller
`timescale 1ns/100ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, fetch_req, strap, good, err;
  logic [7:0]  paddr, fetch_data;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] fetch_addr;
  logic        pready, pslverr, fetch_ready, ext_code_en, boot_done, sdo_in;
  logic        flash_sel_n, flash_sck, sdo_out, sdo_oe_n, miso, dq0, dq0_en;
  int          error_cnt, n_tests, lat, nf0;
  // Pull on the data-out line doubles as the speed strap
  assign sdo_in = !sdo_oe_n ? sdo_out : dq0_en ? dq0 : strap;
  sfcf_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
    .prdata, .pready, .pslverr, .fetch_req, .fetch_addr, .fetch_ready, .fetch_data,
    .ext_code_en, .boot_done, .flash_sel_n, .flash_sck, .sdo_out, .sdo_oe_n, .sdo_in,
    .serial_in_line(miso));
  sfcf_flash_model u_fl (.sel_n(flash_sel_n), .sck(flash_sck), .pin(sdo_in), .good,
    .miso, .dq0, .dq0_en);
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic fetch(input logic [23:0] a, input logic r);
    nf0 = u_fl.nf;
    @(posedge pclk);
    fetch_req <= 1;
    fetch_addr <= a;
    @(posedge pclk);
    fetch_req <= 0;
    for (lat = 1; lat < 3000 && fetch_ready !== 1'b1; lat++)
      @(posedge pclk);
    chk(fetch_ready, r);
    if (r)
      chk(fetch_data, a[7:0] ^ 8'h5a);
  endtask
  task automatic t_boot;
    for (lat = 0; lat < 9000 && boot_done !== 1'b1; lat++)
      @(posedge pclk);
    chk(ext_code_en, 1);
    apb(0, sfcf_pkg::REG_CTRL, 0);
    chk(rd[6:4], 3'h3);
    apb(0, sfcf_pkg::REG_LEN, 0);
    chk(rd[7:0], sfcf_pkg::LEN_RST);
    apb(0, 8'h40, 0);
    chk({err, rd}, 33'h100000000);
    $display("boot test done");
  endtask
  task automatic t_fetch;
    fetch(sfcf_pkg::EXEC_ADDR, 1);
    chk({u_fl.op, u_fl.adr}, {sfcf_pkg::OP_FAST_READ, 24'h0});
    fetch(24'h000001, 1);
    chk(lat < 120, 1);
    chk(u_fl.nf - nf0, 0);
    fetch(24'h000000, 1);
    chk(lat < 4, 1);
    chk(u_fl.nf - nf0, 0);
    $display("fetch test done");
  endtask
  task automatic t_cache;
    for (int i = 0; i < 36; i++)
      fetch(24'h000200 + 24'(i), 1);
    fetch(24'h000204, 1);
    chk(lat < 4, 1);
    fetch(24'h000203, 1);
    chk(lat > 40, 1);
    $display("cache test done");
  endtask
  task automatic t_dual;
    apb(1, sfcf_pkg::REG_CTRL, 32'h2);
    fetch(24'h000300, 1);
    chk(u_fl.op, sfcf_pkg::OP_DUAL_READ);
    fetch(24'h000301, 1);
    apb(1, sfcf_pkg::REG_CTRL, 32'h0);
    $display("dual test done");
  endtask
  task automatic t_cmd;
    logic [63:0] b [7];
    logic [7:0]  n [7];
    logic [63:0] e;
    b = '{64'h9f, 64'h45230120, 64'h45230152, 64'h452301d8, 64'ha545230102, 64'h06,
      64'h8877665544332211};
    n = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h05, 8'h01, 8'h0a};
    for (int k = 0; k < 7; k++)
    begin
      apb(1, sfcf_pkg::REG_CMD0, b[k][31:0]);
      apb(1, sfcf_pkg::REG_CMD1, b[k][63:32]);
      apb(1, sfcf_pkg::REG_LEN, {24'h0, n[k]});
      apb(1, sfcf_pkg::REG_CTRL, 32'h1);
      apb(0, sfcf_pkg::REG_CTRL, 0);
      chk(rd[0], 1);
      for (lat = 0; lat < 900 && rd[0] !== 1'b0; lat++)
        apb(0, sfcf_pkg::REG_CTRL, 0);
      chk(flash_sel_n, 1);
      e = 0;
      for (int i = 0; i < n[k]; i++)
        e = {e[55:0], i < 8 ? b[k][8 * i +: 8] : 8'h00};
      chk(u_fl.sr, e);
      chk(u_fl.cnt, 8 * n[k]);
      apb(0, sfcf_pkg::REG_RESP0, 0);
      if (k == 0)
        chk(rd[23:0], 24'h332211);
    end
    $display("command test done");
  endtask
  task automatic t_reset2(input logic g);
    presetn <= 0;
    strap <= 1;
    good <= g;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    for (lat = 0; lat < 9000 && boot_done !== 1'b1; lat++)
      @(posedge pclk);
    chk(ext_code_en, g);
    apb(0, sfcf_pkg::REG_CTRL, 0);
    chk(rd[6:4], {2'h3, g});
    apb(1, sfcf_pkg::REG_CTRL, 32'h2);
    fetch(24'h000010, g);
    chk(u_fl.op, sfcf_pkg::OP_FAST_READ);
    $display("reset test done");
  endtask
  initial
  begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  initial
  begin
    #200000;
    error_cnt++;
    end_of_test;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, fetch_req, strap, paddr, pwdata, fetch_addr} = 0;
    good = 1;
    error_cnt = 0;
    n_tests = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_boot;
    t_fetch;
    t_cache;
    t_dual;
    t_cmd;
    t_reset2(1);
    t_reset2(0);
    end_of_test;
  end
endmodule
bind sfcf_top sfcf_chk u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
  .fetch_ready, .ext_code_en, .boot_done, .flash_sel_n, .flash_sck, .sdo_oe_n);
